// ### tlpe_pkg.sv
// shared constants for the tributary line port
package tlpe_pkg;
    localparam int          SYM_W       = 2;
    localparam int          SYMS        = 8;
    localparam int          WORD_W      = SYM_W * SYMS;
    localparam int          FIFO_DEPTH  = 32;
    localparam int          CNT_W       = 3;
    localparam logic [2:0]  CNT_LAST    = 3'h7;
    localparam logic [2:0]  CNT_RST     = 3'h0;
    localparam logic        MODE_DS3E3  = 1'h0;
    localparam logic        MODE_STS1   = 1'h1;
    localparam logic        EDGE_RISE   = 1'h0;
    localparam logic        EDGE_FALL   = 1'h1;
    localparam logic [1:0]  SYM_IDLE    = 2'h0;
    localparam logic [15:0] WORD_RST    = 16'h0000;
    localparam int          POS_BIT     = 0;
    localparam int          NEG_BIT     = 1;
endpackage

// ### tlpe_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module tlpe_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 32
) (
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_ptr_r;
    logic [AW:0]  rd_ptr_r;

    wire full  = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                 (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    wire empty = (wr_ptr_r == rd_ptr_r);
    wire push  = in_valid && !full;
    wire pop   = out_ready && !empty;

    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr_r[AW-1:0]];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) wr_ptr_r <= wr_ptr_r + (AW+1)'(1);
            if (pop)  rd_ptr_r <= rd_ptr_r + (AW+1)'(1);
        end
    end
endmodule // tlpe_fifo

// ### tlpe_port.sv
// tributary line port: dual or single rail, selectable edges, both ways
// Functional notes
// - DS3/E3 mode captures both receive rails on the chosen rx edge.
// - STS-1 mode uses only the positive receive rail, ignoring the negative.
// - STS-1 mode captures the single receive rail on the chosen rx edge.
// - DS3/E3 mode launches both transmit rails on the chosen tx edge.
// - STS-1 mode sends only the even word bits on the positive tx rail; odd bits are dropped and negative stays low.
// - STS-1 mode launches the single transmit rail on the chosen tx edge.
`timescale 1ns/1ps
module tlpe_port (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        mode_sts1,
    input  wire logic        rx_edge_fall,
    input  wire logic        tx_edge_fall,
    input  wire logic        line_rx_clock,
    input  wire logic        line_rx_pos_rail,
    input  wire logic        line_rx_neg_rail,
    input  wire logic        line_tx_clock,
    output logic             line_tx_pos_rail,
    output logic             line_tx_neg_rail,
    output logic [15:0]      rx_word,
    output logic             rx_valid,
    input  wire logic        rx_ready,
    input  wire logic [15:0] tx_word,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    output logic             rx_overrun,
    output logic             tx_underrun
);
    // receive, line_rx_clock domain
    logic        rx_mode_s1_r;
    logic        rx_mode_s2_r;
    logic        rx_edge_s1_r;
    logic        rx_edge_s2_r;
    logic        rx_rise_pos_r;
    logic        rx_rise_neg_r;
    logic        rx_fall_pos_r;
    logic        rx_fall_neg_r;
    logic [15:0] rx_sh_r;
    logic [2:0]  rx_cnt_r;
    logic [15:0] rx_hold_r;
    logic        rx_tgl_r;

    // each port instance keeps its own settings; edges are separate
    always_ff @(posedge line_rx_clock or negedge arst_n) begin
        if (!arst_n) begin
            rx_mode_s1_r <= tlpe_pkg::MODE_DS3E3;
            rx_mode_s2_r <= tlpe_pkg::MODE_DS3E3;
            rx_edge_s1_r <= tlpe_pkg::EDGE_RISE;
            rx_edge_s2_r <= tlpe_pkg::EDGE_RISE;
        end else begin
            rx_mode_s1_r <= mode_sts1;
            rx_mode_s2_r <= rx_mode_s1_r;
            rx_edge_s1_r <= rx_edge_fall;
            rx_edge_s2_r <= rx_edge_s1_r;
        end
    end

    always_ff @(posedge line_rx_clock or negedge arst_n) begin
        if (!arst_n) begin
            rx_rise_pos_r <= 1'h0;
            rx_rise_neg_r <= 1'h0;
        end else begin
            rx_rise_pos_r <= line_rx_pos_rail;
            rx_rise_neg_r <= line_rx_neg_rail;
        end
    end

    always_ff @(negedge line_rx_clock or negedge arst_n) begin
        if (!arst_n) begin
            rx_fall_pos_r <= 1'h0;
            rx_fall_neg_r <= 1'h0;
        end else begin
            rx_fall_pos_r <= line_rx_pos_rail;
            rx_fall_neg_r <= line_rx_neg_rail;
        end
    end

    // falling samples are re-timed by the next rising edge
    wire rx_use_fall = (rx_edge_s2_r == tlpe_pkg::EDGE_FALL);
    wire rx_is_sts1  = (rx_mode_s2_r == tlpe_pkg::MODE_STS1);
    wire rx_samp_pos = rx_use_fall ? rx_fall_pos_r :
                       rx_rise_pos_r;
    wire rx_samp_neg = rx_is_sts1 ? 1'h0 :
                       (rx_use_fall ? rx_fall_neg_r : rx_rise_neg_r);
    wire [1:0]  rx_sym   = {rx_samp_neg, rx_samp_pos};
    wire [15:0] rx_shn   = {rx_sym, rx_sh_r[15:2]};
    wire        rx_wlast = (rx_cnt_r == tlpe_pkg::CNT_LAST);

    // first symbol lands in the low bits of the word
    always_ff @(posedge line_rx_clock or negedge arst_n) begin
        if (!arst_n) begin
            rx_sh_r   <= tlpe_pkg::WORD_RST;
            rx_cnt_r  <= tlpe_pkg::CNT_RST;
            rx_hold_r <= tlpe_pkg::WORD_RST;
            rx_tgl_r  <= 1'h0;
        end else begin
            rx_sh_r  <= rx_shn;
            rx_cnt_r <= rx_cnt_r + 3'h1;
            if (rx_wlast) begin
                rx_hold_r <= rx_shn;
                rx_tgl_r  <= !rx_tgl_r;
            end
        end
    end

    // receive, clk_sys side
    // hold word stays put for eight line clocks, far longer than the sync
    logic rx_tgl_s1_r;
    logic rx_tgl_s2_r;
    logic rx_tgl_s3_r;
    logic rx_ovr_r;

    wire rx_evt = rx_tgl_s2_r ^ rx_tgl_s3_r;
    wire rx_in_ready;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_tgl_s1_r <= 1'h0;
            rx_tgl_s2_r <= 1'h0;
            rx_tgl_s3_r <= 1'h0;
            rx_ovr_r    <= 1'h0;
        end else begin
            rx_tgl_s1_r <= rx_tgl_r;
            rx_tgl_s2_r <= rx_tgl_s1_r;
            rx_tgl_s3_r <= rx_tgl_s2_r;
            rx_ovr_r    <= rx_evt && !rx_in_ready;
        end
    end

    assign rx_overrun = rx_ovr_r;

    tlpe_fifo #(
        .W     (tlpe_pkg::WORD_W),
        .DEPTH (tlpe_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .in_data   (rx_hold_r),
        .in_valid  (rx_evt),
        .in_ready  (rx_in_ready),
        .out_data  (rx_word),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );

    // transmit, clk_sys side
    logic [15:0] tx_nxt_r;
    logic        tx_ack_r;
    logic        tx_req_s1_r;
    logic        tx_req_s2_r;
    logic        tx_unr_s1_r;
    logic        tx_unr_s2_r;
    logic        tx_unr_s3_r;
    logic        tx_req_r;
    logic        tx_unr_tgl_r;

    wire [15:0] tx_fifo_data;
    wire        tx_fifo_valid;
    wire        tx_slot_free = (tx_req_s2_r == tx_ack_r);
    wire        tx_load      = tx_slot_free && tx_fifo_valid;

    tlpe_fifo #(
        .W     (tlpe_pkg::WORD_W),
        .DEPTH (tlpe_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .in_data   (tx_word),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (tx_fifo_data),
        .out_valid (tx_fifo_valid),
        .out_ready (tx_slot_free)
    );

    // word is written in the same cycle that ack flips, and not touched until req returns
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_nxt_r    <= tlpe_pkg::WORD_RST;
            tx_ack_r    <= 1'h0;
            tx_req_s1_r <= 1'h0;
            tx_req_s2_r <= 1'h0;
            tx_unr_s1_r <= 1'h0;
            tx_unr_s2_r <= 1'h0;
            tx_unr_s3_r <= 1'h0;
        end else begin
            tx_req_s1_r <= tx_req_r;
            tx_req_s2_r <= tx_req_s1_r;
            tx_unr_s1_r <= tx_unr_tgl_r;
            tx_unr_s2_r <= tx_unr_s1_r;
            tx_unr_s3_r <= tx_unr_s2_r;
            if (tx_load) begin
                tx_nxt_r <= tx_fifo_data;
                tx_ack_r <= !tx_ack_r;
            end
        end
    end

    assign tx_underrun = tx_unr_s2_r ^ tx_unr_s3_r;

    // transmit, line_tx_clock domain
    logic        tx_mode_s1_r;
    logic        tx_mode_s2_r;
    logic        tx_edge_s1_r;
    logic        tx_edge_s2_r;
    logic        tx_ack_s1_r;
    logic        tx_ack_s2_r;
    logic [15:0] tx_sh_r;
    logic [2:0]  tx_cnt_r;
    logic        tx_rise_pos_r;
    logic        tx_rise_neg_r;
    logic        tx_fall_pos_r;
    logic        tx_fall_neg_r;

    always_ff @(posedge line_tx_clock or negedge arst_n) begin
        if (!arst_n) begin
            tx_mode_s1_r <= tlpe_pkg::MODE_DS3E3;
            tx_mode_s2_r <= tlpe_pkg::MODE_DS3E3;
            tx_edge_s1_r <= tlpe_pkg::EDGE_RISE;
            tx_edge_s2_r <= tlpe_pkg::EDGE_RISE;
            tx_ack_s1_r  <= 1'h0;
            tx_ack_s2_r  <= 1'h0;
        end else begin
            tx_mode_s1_r <= mode_sts1;
            tx_mode_s2_r <= tx_mode_s1_r;
            tx_edge_s1_r <= tx_edge_fall;
            tx_edge_s2_r <= tx_edge_s1_r;
            tx_ack_s1_r  <= tx_ack_r;
            tx_ack_s2_r  <= tx_ack_s1_r;
        end
    end

    wire tx_have  = (tx_ack_s2_r != tx_req_r);
    wire tx_start = (tx_cnt_r == tlpe_pkg::CNT_RST);
    wire tx_take  = tx_start && tx_have;
    wire tx_gap   = tx_start && !tx_have;
    wire [1:0] tx_sym = tx_take ? tx_nxt_r[1:0] :
                        (tx_gap ? tlpe_pkg::SYM_IDLE : tx_sh_r[1:0]);
    wire tx_is_sts1 = (tx_mode_s2_r == tlpe_pkg::MODE_STS1);

    // an empty slot sends idle and retries on the next line clock
    always_ff @(posedge line_tx_clock or negedge arst_n) begin
        if (!arst_n) begin
            tx_sh_r       <= tlpe_pkg::WORD_RST;
            tx_cnt_r      <= tlpe_pkg::CNT_RST;
            tx_req_r      <= 1'h0;
            tx_unr_tgl_r  <= 1'h0;
            tx_rise_pos_r <= 1'h0;
            tx_rise_neg_r <= 1'h0;
        end else begin
            tx_sh_r       <= tx_take ? (tx_nxt_r >> 2) : (tx_sh_r >> 2);
            tx_cnt_r      <= tx_gap ? tlpe_pkg::CNT_RST : tx_cnt_r + 3'h1;
            tx_req_r      <= tx_take ? !tx_req_r : tx_req_r;
            tx_unr_tgl_r  <= tx_gap ? !tx_unr_tgl_r : tx_unr_tgl_r;
            tx_rise_pos_r <= tx_sym[tlpe_pkg::POS_BIT];
            tx_rise_neg_r <= tx_is_sts1 ? 1'h0 :
                             tx_sym[tlpe_pkg::NEG_BIT];
        end
    end

    // falling launch re-times the rising flops by half a line clock
    always_ff @(negedge line_tx_clock or negedge arst_n) begin
        if (!arst_n) begin
            tx_fall_pos_r <= 1'h0;
            tx_fall_neg_r <= 1'h0;
        end else begin
            tx_fall_pos_r <= tx_rise_pos_r;
            tx_fall_neg_r <= tx_rise_neg_r;
        end
    end

    wire tx_use_fall = (tx_edge_s2_r == tlpe_pkg::EDGE_FALL);
    assign line_tx_pos_rail = tx_use_fall ? tx_fall_pos_r
                                          : tx_rise_pos_r;
    assign line_tx_neg_rail = tx_use_fall ? tx_fall_neg_r
                                          : tx_rise_neg_r;
endmodule // tlpe_port

// ### tlpe_port_chk.sv
// pin-level assertions for the tributary line port
`timescale 1ns/1ps
module tlpe_port_chk (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        mode_sts1,
    input wire logic        tx_edge_fall,
    input wire logic        line_tx_clock,
    input wire logic        line_tx_pos_rail,
    input wire logic        line_tx_neg_rail,
    input wire logic [15:0] rx_word,
    input wire logic        rx_valid,
    input wire logic        rx_ready,
    input wire logic        tx_ready,
    input wire logic        rx_overrun
);
    logic [1:0]  fcap_r;
    logic [1:0]  rcap_r;
    logic [11:0] sts_r;
    wire  [1:0]  rails = {line_tx_neg_rail, line_tx_pos_rail};
    // rails seen mid-cycle; must match at the next opposite edge
    always_ff @(negedge line_tx_clock or negedge arst_n)
        if (!arst_n) fcap_r <= 2'h0;
        else fcap_r <= rails;
    always_ff @(posedge line_tx_clock or negedge arst_n)
        if (!arst_n) rcap_r <= 2'h0;
        else rcap_r <= rails;
    // saturates well past a full fifo of older dual-rail words
    always_ff @(posedge clk_sys or negedge arst_n)
        if (!arst_n) sts_r <= 12'h000;
        else if (!mode_sts1) sts_r <= 12'h000;
        else if (sts_r != 12'hfff) sts_r <= sts_r + 12'h001;
    a_rise_launch: assert property (
        @(posedge line_tx_clock) disable iff (!arst_n)
        !tx_edge_fall |-> rails == fcap_r) else $error("rails moved late");
    a_fall_launch: assert property (
        @(negedge line_tx_clock) disable iff (!arst_n)
        tx_edge_fall |-> rails == rcap_r) else $error("rails moved early");
    a_neg_quiet: assert property (
        @(posedge line_tx_clock) disable iff (!arst_n)
        mode_sts1 && $past(mode_sts1, 4) |-> !line_tx_neg_rail)
        else $error("neg rail active in single rail");
    a_reset_idle: assert property (
        @(posedge clk_sys) !arst_n |-> rails == 2'h0 && !rx_valid && tx_ready)
        else $error("outputs not idle in reset");
    a_rx_hold: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
        else $error("rx word not held");
    a_ovr_once: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        rx_overrun |=> !rx_overrun) else $error("overrun pulse too long");
    a_ovr_full: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        rx_overrun |-> $past(rx_valid)) else $error("overrun while empty");
    a_rx_single: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        rx_valid && sts_r == 12'hfff |-> (rx_word & 16'haaaa) == 16'h0000)
        else $error("neg bits in single rail word");
endmodule // tlpe_port_chk
bind tlpe_port tlpe_port_chk chk_u (.clk_sys, .arst_n, .mode_sts1,
    .tx_edge_fall, .line_tx_clock, .line_tx_pos_rail, .line_tx_neg_rail,
    .rx_word, .rx_valid, .rx_ready, .tx_ready, .rx_overrun);

// ### tlpe_liu_model.sv
// line unit model: free-running line clocks, edge-windowed rails
`timescale 1ns/1ps
module tlpe_liu_model (
    input  wire logic       rx_edge_fall,
    input  wire logic       tx_edge_fall,
    input  wire logic [1:0] rx_sym,
    input  wire logic [1:0] tx_expect,
    input  wire logic       clr,
    input  wire logic       line_tx_pos_rail,
    input  wire logic       line_tx_neg_rail,
    output logic            line_rx_clock,
    output logic            line_rx_pos_rail,
    output logic            line_rx_neg_rail,
    output logic            line_tx_clock,
    output logic [7:0]      hits
);
    logic [1:0] q = 2'h0;
    wire        near = (q[0] ^ q[1]) ^ rx_edge_fall;
    // hits is cleared by the first line edge while clr is high
    always #20 q = q + 2'h1;
    initial begin
        line_tx_clock = 1'b0;
        #13.1;
        forever #40 line_tx_clock = ~line_tx_clock;
    end
    assign line_rx_clock = q[1];
    // symbol only valid around the chosen edge, inverted around the other
    assign {line_rx_neg_rail, line_rx_pos_rail} =
        near ? rx_sym : ~rx_sym;
    // sample half a period after the launch edge
    always @(line_tx_clock)
        if (clr) hits <= 8'h00;
        else if (line_tx_clock == tx_edge_fall &&
                 {line_tx_neg_rail, line_tx_pos_rail} == tx_expect)
            hits <= hits + 8'h01;
endmodule // tlpe_liu_model

// ### test_tributary_line_port_edge_rail_select.sv
// self-checking bench for the tributary line port
`timescale 1ns/1ps
module test_tributary_line_port_edge_rail_select;
    typedef struct packed {
        logic m, re, te; logic [1:0] rs; logic [15:0] rx, tw; logic [1:0] ts;
    } tlpe_row_t;
    localparam tlpe_row_t ROWS [8] = '{
        '{1'h0, 1'h0, 1'h0, 2'h1, 16'h5555, 16'hffff, 2'h3},
        '{1'h0, 1'h1, 1'h1, 2'h2, 16'haaaa, 16'h5555, 2'h1},
        '{1'h0, 1'h0, 1'h1, 2'h3, 16'hffff, 16'haaaa, 2'h2},
        '{1'h0, 1'h1, 1'h0, 2'h1, 16'h5555, 16'hffff, 2'h3},
        '{1'h1, 1'h0, 1'h0, 2'h3, 16'h5555, 16'hffff, 2'h1},
        '{1'h1, 1'h1, 1'h1, 2'h3, 16'h5555, 16'h5555, 2'h1},
        '{1'h1, 1'h0, 1'h1, 2'h3, 16'h5555, 16'hffff, 2'h1},
        '{1'h1, 1'h1, 1'h0, 2'h3, 16'h5555, 16'h5555, 2'h1}};
    logic        clk_sys = 1'b0, arst_n = 1'b0, clr = 1'b1;
    logic        mode_sts1 = 1'b0, rx_edge_fall = 1'b0, tx_edge_fall = 1'b0;
    logic        rx_ready = 1'b0, tx_valid = 1'b0;
    logic [15:0] tx_word = 16'h0000;
    logic [1:0]  rx_sym = 2'h0, tx_expect = 2'h0;
    logic        line_rx_clock, line_rx_pos_rail, line_rx_neg_rail;
    logic        line_tx_clock, line_tx_pos_rail, line_tx_neg_rail;
    logic        rx_valid, tx_ready, rx_overrun, tx_underrun;
    logic [15:0] rx_word;
    logic [7:0]  hits;
    int          num_errors = 0, n_tests = 0;
    wire  [3:0]  flags = {tx_underrun, rx_overrun, rx_valid, tx_ready};
    tlpe_port dut_u (.clk_sys, .arst_n, .mode_sts1, .rx_edge_fall,
        .tx_edge_fall, .line_rx_clock, .line_rx_pos_rail, .line_rx_neg_rail,
        .line_tx_clock, .line_tx_pos_rail, .line_tx_neg_rail, .rx_word,
        .rx_valid, .rx_ready, .tx_word, .tx_valid, .tx_ready, .rx_overrun,
        .tx_underrun);
    tlpe_liu_model liu_u (.rx_edge_fall, .tx_edge_fall, .rx_sym, .tx_expect,
        .clr, .line_tx_pos_rail, .line_tx_neg_rail, .line_rx_clock,
        .line_rx_pos_rail, .line_rx_neg_rail, .line_tx_clock, .hits);
    always #4 clk_sys = ~clk_sys;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // flags sampled as they stood just before each edge
    task automatic wait_flag(input int i, input logic v, input int lim);
        for (int k = 0; k < lim && flags[i] !== v; k++) @(posedge clk_sys);
        chk(flags[i], v);
    endtask
    task results;
        if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin : watchdog
        #500us;
        num_errors++;
        results();
    end
    initial begin : main
        repeat (12) @(posedge clk_sys);
        chk(flags, 4'h1);
        arst_n <= 1'b1;
        rx_ready <= 1'b1;
        // dual-rail rows first so the single-rail stretch runs long
        foreach (ROWS[i]) begin
            @(posedge clk_sys);
            {mode_sts1, rx_edge_fall, tx_edge_fall, rx_sym, tx_expect, tx_word}
                <= {ROWS[i].m, ROWS[i].re, ROWS[i].te, ROWS[i].rs, ROWS[i].ts,
                    ROWS[i].tw};
            clr <= 1'b1;
            repeat (600) @(posedge clk_sys);
            wait_flag(1, 1'b1, 200);
            chk(rx_word, ROWS[i].rx);
            clr <= 1'b0;
            tx_valid <= 1'b1;
            repeat (3) @(posedge clk_sys);
            tx_valid <= 1'b0;
            repeat (400) @(posedge clk_sys);
            chk(hits, 8'h18);
        end
        rx_ready <= 1'b0;
        tx_valid <= 1'b1;
        wait_flag(0, 1'b0, 100);
        tx_valid <= 1'b0;
        wait_flag(2, 1'b1, 3000);
        chk(flags[1], 1'b1);
        rx_ready <= 1'b1;
        wait_flag(1, 1'b0, 60);
        wait_flag(3, 1'b1, 3500);
        // mid-run reset with a word queued; nothing stale may be sent after
        tx_valid <= 1'b1;
        @(posedge clk_sys);
        tx_valid <= 1'b0;
        arst_n   <= 1'b0;
        clr      <= 1'b1;
        repeat (12) @(posedge clk_sys);
        chk(flags, 4'h1);
        chk({line_tx_neg_rail, line_tx_pos_rail}, 2'h0);
        arst_n <= 1'b1;
        // first word after release is partly reset symbols, so skip ahead
        repeat (300) @(posedge clk_sys);
        wait_flag(1, 1'b1, 200);
        chk(rx_word, 16'h5555);
        clr      <= 1'b0;
        tx_valid <= 1'b1;
        @(posedge clk_sys);
        tx_valid <= 1'b0;
        repeat (400) @(posedge clk_sys);
        chk(hits, 8'h08);
        results();
    end
endmodule // test_tributary_line_port_edge_rail_select
